// ===== design/mac_status_pkg.sv
// How it works
// [RULE1] Flags latch high; write one clears
// [RULE2] Bit 9 set on receive watchdog expiry
// [RULE3] Bit 8 set while receive is stopped
// [RULE4] Bit 7 set when no receive descriptor
// [RULE5] Missing receive descriptor suspends receive process
// [RULE6] Host returns ownership, then issues poll demand
// [RULE7] New frame resumes receive when descriptor owned
// [RULE8] Bit 6 set when frame reception finishes
// [RULE9] Bit 5 set on FIFO underflow mid-frame
// [RULE10] Underflow suspends transmit, marks descriptor bit 1
// [RULE11] Bit 3 set on transmit jabber expiry
// [RULE12] Jabber time-out stops the transmit process
// [RULE13] Jabber time-out marks descriptor status bit 14
// [RULE14] Both status registers show the same flags
// [RULE15] Reserved bits 10 and 4 read zero
package mac_status_pkg;

    localparam int FLAG_W = 15;
    localparam int ADR_W = 8;

    // Register byte offsets
    localparam logic [ADR_W-1:0] OFS_SECONDARY_STATUS = 8'h00;
    localparam logic [ADR_W-1:0] OFS_PRIMARY_STATUS = 8'h04;
    localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [ADR_W-1:0] OFS_PROC_CMD = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_PROC_STATE = 8'h10;

    // Flag positions in the status registers
    localparam int BIT_RX_WDOG = 9;
    localparam int BIT_RX_STOP = 8;
    localparam int BIT_RX_NODESC = 7;
    localparam int BIT_RX_DONE = 6;
    localparam int BIT_TX_UFLOW = 5;
    localparam int BIT_TX_JABBER = 3;
    localparam logic [FLAG_W-1:0] FLAG_IMPL = 15'h03E8;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 15'h0000;

    // Command register bits, write one to act
    localparam int CMD_RX_START = 0;
    localparam int CMD_RX_STOP = 1;
    localparam int CMD_RX_POLL = 2;
    localparam int CMD_TX_START = 8;
    localparam int CMD_TX_STOP = 9;
    localparam int CMD_TX_POLL = 10;

    // State register fields
    localparam int STATE_RX_LSB = 0;
    localparam int STATE_TX_LSB = 8;

    // Transmit descriptor first status word bits
    localparam int DESC_UFLOW_BIT = 1;
    localparam int DESC_JABBER_BIT = 14;

    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        PROC_STOP = 2'b00,
        PROC_RUN = 2'b01,
        PROC_SUSP = 2'b10
    } proc_state_t;

endpackage

// ===== design/flag_bank_if.sv
`timescale 1ns/1ps
interface flag_bank_if #(parameter int W = 15);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] flags;

    modport bank (input set, input clr, output flags);
    modport owner (output set, output clr, input flags);
endinterface

// ===== design/sticky_flag_bank.sv
`timescale 1ns/1ps
module sticky_flag_bank
    import mac_status_pkg::*;
#(
    parameter int W = FLAG_W,
    parameter logic [FLAG_W-1:0] IMPL = FLAG_IMPL
) (
    input wire logic clk_i,
    input wire logic rst_i,
    flag_bank_if.bank fb
);
    typedef struct packed {
        logic [W-1:0] flags;
    } bank_st_t;

    bank_st_t st;
    bank_st_t next_st;

    always_comb begin
        next_st = st;
        for (int i = 0; i < W; i++) begin
            if (IMPL[i]) begin
                // [RULE1] set beats clear
                next_st.flags[i] = fb.set[i] | (st.flags[i] & ~fb.clr[i]);
            end else begin
                // [RULE15] reserved stay zero
                next_st.flags[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.flags <= FLAG_RESET[W-1:0];
        end else begin
            st <= next_st;
        end
    end

    assign fb.flags = st.flags;
endmodule // sticky_flag_bank

// ===== design/dma_proc_fsm.sv
`timescale 1ns/1ps
module dma_proc_fsm
    import mac_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic suspend_i,
    input wire logic resume_i,
    output proc_state_t state_o
);
    typedef struct packed {
        proc_state_t state;
    } fsm_st_t;

    fsm_st_t st;
    fsm_st_t next_st;

    // Stop outranks everything so a fault never leaves the process running
    always_comb begin
        next_st = st;
        case (st.state)
            PROC_STOP: begin
                if (start_i && !stop_i) begin
                    next_st.state = PROC_RUN;
                end
            end
            PROC_RUN: begin
                if (stop_i) begin
                    next_st.state = PROC_STOP;
                end else if (suspend_i) begin
                    next_st.state = PROC_SUSP;
                end
            end
            PROC_SUSP: begin
                if (stop_i) begin
                    next_st.state = PROC_STOP;
                end else if (resume_i || start_i) begin
                    next_st.state = PROC_RUN;
                end
            end
            default: begin
                next_st.state = PROC_STOP;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.state <= PROC_STOP;
        end else begin
            st <= next_st;
        end
    end

    assign state_o = st.state;
endmodule // dma_proc_fsm

// ===== design/mac_status_flags_low.sv
`timescale 1ns/1ps
module mac_status_flags_low
    import mac_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [mac_status_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Events from the receive engine
    input wire logic rx_watchdog_expired_i,
    input wire logic rx_desc_fetch_fail_i,
    input wire logic rx_desc_owned_i,
    input wire logic rx_frame_arrive_i,
    input wire logic rx_frame_done_i,
    // Events from the transmit engine
    input wire logic tx_fifo_empty_i,
    input wire logic tx_frame_active_i,
    input wire logic tx_jabber_expired_i,
    // Descriptor write-back, process status and interrupt
    output logic [31:0] tx_desc_status_word_o,
    output logic tx_desc_status_we_o,
    output mac_status_pkg::proc_state_t rx_state_o,
    output mac_status_pkg::proc_state_t tx_state_o,
    output logic irq_o
);
    import mac_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [FLAG_W-1:0] mask;
        logic irq;
        logic rx_start;
        logic rx_stop;
        logic rx_poll;
        logic tx_start;
        logic tx_stop;
        logic tx_poll;
        logic [31:0] desc_word;
        logic desc_we;
        proc_state_t rx_state;
        proc_state_t tx_state;
    } top_st_t;

    top_st_t st;
    top_st_t next_st;

    flag_bank_if #(.W(FLAG_W)) fb ();

    proc_state_t rx_state;
    proc_state_t tx_state;

    logic bus_req;
    logic wr_req;
    logic rd_req;
    logic [31:0] lane_mask;
    logic [31:0] wdata;
    logic hit_status;
    logic tx_underflow;
    logic rx_suspend;
    logic rx_resume;
    logic tx_suspend;
    logic tx_stop_ev;
    logic [FLAG_W-1:0] flag_set;
    logic [31:0] state_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // A new grant is held off in the cycle after a grant so each request gets one ack
    assign bus_req = wb_cyc_i & wb_stb_i & ~st.ack;
    assign wr_req = bus_req & wb_we_i;
    assign rd_req = bus_req & ~wb_we_i;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            lane_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
    end

    assign wdata = wb_dat_i & lane_mask;

    // [RULE14] both views decode alike
    assign hit_status = (wb_adr_i == OFS_SECONDARY_STATUS) ||
                        (wb_adr_i == OFS_PRIMARY_STATUS);

    ////////////////////////////////////////////////////////////////////////////////
    // Event sources

    // [RULE9] underflow only mid-frame
    assign tx_underflow = tx_fifo_empty_i & tx_frame_active_i;

    // [RULE5] no descriptor suspends
    assign rx_suspend = rx_desc_fetch_fail_i;

    // [RULE6] poll demand resumes
    // [RULE7] owned frame resumes
    assign rx_resume = st.rx_poll | (rx_frame_arrive_i & rx_desc_owned_i);

    // [RULE10] underflow suspends transmit
    assign tx_suspend = tx_underflow;

    // [RULE12] jabber stops transmit
    assign tx_stop_ev = st.tx_stop | tx_jabber_expired_i;

    always_comb begin
        flag_set = '0;
        // [RULE2] watchdog flag
        flag_set[BIT_RX_WDOG] = rx_watchdog_expired_i;
        // [RULE3] stopped flag set each cycle the receive state is PROC_STOP
        flag_set[BIT_RX_STOP] = (rx_state == PROC_STOP);
        // [RULE4] descriptor unavailable flag
        flag_set[BIT_RX_NODESC] = rx_desc_fetch_fail_i;
        // [RULE8] reception finished flag
        flag_set[BIT_RX_DONE] = rx_frame_done_i;
        flag_set[BIT_TX_UFLOW] = tx_underflow;
        // [RULE11] jabber flag
        flag_set[BIT_TX_JABBER] = tx_jabber_expired_i;
    end

    assign fb.set = flag_set;
    // [RULE1] write one clears
    assign fb.clr = (wr_req && hit_status) ? wdata[FLAG_W-1:0] : '0;

    ////////////////////////////////////////////////////////////////////////////////
    // Submodules

    sticky_flag_bank #(
        .W(FLAG_W),
        .IMPL(FLAG_IMPL)
    ) u_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fb(fb.bank)
    );

    dma_proc_fsm u_rx_fsm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(st.rx_start),
        .stop_i(st.rx_stop),
        .suspend_i(rx_suspend),
        .resume_i(rx_resume),
        .state_o(rx_state)
    );

    dma_proc_fsm u_tx_fsm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(st.tx_start),
        .stop_i(tx_stop_ev),
        .suspend_i(tx_suspend),
        .resume_i(st.tx_poll),
        .state_o(tx_state)
    );

    always_comb begin
        state_word = WORD_ZERO;
        state_word[STATE_RX_LSB +: 2] = rx_state;
        state_word[STATE_TX_LSB +: 2] = tx_state;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_st = st;
        next_st.ack = bus_req;
        next_st.rx_start = 1'b0;
        next_st.rx_stop = 1'b0;
        next_st.rx_poll = 1'b0;
        next_st.tx_start = 1'b0;
        next_st.tx_stop = 1'b0;
        next_st.tx_poll = 1'b0;
        next_st.desc_we = 1'b0;
        next_st.desc_word = WORD_ZERO;
        next_st.rx_state = rx_state;
        next_st.tx_state = tx_state;

        if (rd_req) begin
            next_st.rdata = WORD_ZERO;
            case (wb_adr_i)
                OFS_SECONDARY_STATUS, OFS_PRIMARY_STATUS: begin
                    // [RULE15] unimplemented bits read zero
                    next_st.rdata[FLAG_W-1:0] = fb.flags & FLAG_IMPL;
                end
                OFS_IRQ_MASK: begin
                    next_st.rdata[FLAG_W-1:0] = st.mask;
                end
                OFS_PROC_STATE: begin
                    next_st.rdata = state_word;
                end
                default: begin
                    next_st.rdata = WORD_ZERO;
                end
            endcase
        end

        if (wr_req) begin
            case (wb_adr_i)
                OFS_IRQ_MASK: begin
                    next_st.mask = (st.mask & ~lane_mask[FLAG_W-1:0]) |
                                   (wdata[FLAG_W-1:0] & FLAG_IMPL);
                end
                OFS_PROC_CMD: begin
                    next_st.rx_start = wdata[CMD_RX_START];
                    next_st.rx_stop = wdata[CMD_RX_STOP];
                    next_st.rx_poll = wdata[CMD_RX_POLL];
                    next_st.tx_start = wdata[CMD_TX_START];
                    next_st.tx_stop = wdata[CMD_TX_STOP];
                    next_st.tx_poll = wdata[CMD_TX_POLL];
                end
                default: begin
                    next_st.mask = st.mask;
                end
            endcase
        end

        // Descriptor write-back; both marks merge when they coincide
        if (tx_underflow || tx_jabber_expired_i) begin
            next_st.desc_we = 1'b1;
            // [RULE10] underflow mark
            next_st.desc_word[DESC_UFLOW_BIT] = tx_underflow;
            // [RULE13] jabber mark
            next_st.desc_word[DESC_JABBER_BIT] = tx_jabber_expired_i;
        end

        // Level output; one cycle behind the flags so it comes from a flop
        next_st.irq = |(fb.flags & st.mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.ack <= 1'b0;
            st.rdata <= WORD_ZERO;
            st.mask <= '0;
            st.irq <= 1'b0;
            st.rx_start <= 1'b0;
            st.rx_stop <= 1'b0;
            st.rx_poll <= 1'b0;
            st.tx_start <= 1'b0;
            st.tx_stop <= 1'b0;
            st.tx_poll <= 1'b0;
            st.desc_word <= WORD_ZERO;
            st.desc_we <= 1'b0;
            st.rx_state <= PROC_STOP;
            st.tx_state <= PROC_STOP;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign irq_o = st.irq;
    assign tx_desc_status_word_o = st.desc_word;
    assign tx_desc_status_we_o = st.desc_we;
    assign rx_state_o = st.rx_state;
    assign tx_state_o = st.tx_state;

endmodule // mac_status_flags_low

// ===== verif/mac_status_flags_low_properties.sv
`timescale 1ns/1ps
module mac_status_flags_low_checker
    import mac_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [mac_status_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rx_desc_fetch_fail_i,
    input wire logic rx_desc_owned_i,
    input wire logic rx_frame_arrive_i,
    input wire logic tx_fifo_empty_i,
    input wire logic tx_frame_active_i,
    input wire logic tx_jabber_expired_i,
    input wire logic [31:0] tx_desc_status_word_o,
    input wire logic tx_desc_status_we_o,
    input wire mac_status_pkg::proc_state_t rx_state_o,
    input wire mac_status_pkg::proc_state_t tx_state_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic uflow;
    assign uflow = tx_fifo_empty_i && tx_frame_active_i;
    ////////////////////////////////////////////////////////////////////////////////
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    chk_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    chk_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    chk_reserved_zero: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i == OFS_SECONDARY_STATUS |-> (wb_dat_o & ~32'h0000_03E8) == 32'h0)
        else $error("unused status bit set");
    chk_uflow_desc: assert property (uflow |=> tx_desc_status_we_o
        && tx_desc_status_word_o[DESC_UFLOW_BIT]) else $error("underflow not written back");
    chk_jabber_desc: assert property (tx_jabber_expired_i |=> tx_desc_status_we_o
        && tx_desc_status_word_o[DESC_JABBER_BIT]) else $error("jabber not written back");
    chk_desc_cause: assert property (tx_desc_status_we_o
        |-> $past(uflow) || $past(tx_jabber_expired_i)) else $error("stray write-back");
    chk_jabber_stop: assert property (tx_jabber_expired_i
        |-> ##2 tx_state_o == PROC_STOP) else $error("jabber did not stop tx");
    chk_uflow_susp: assert property (uflow && tx_state_o == PROC_RUN
        |-> ##2 tx_state_o == PROC_SUSP) else $error("underflow did not suspend tx");
    chk_rx_suspend: assert property (rx_desc_fetch_fail_i && rx_state_o == PROC_RUN
        |-> ##2 rx_state_o == PROC_SUSP) else $error("rx not suspended");
    chk_rx_resume: assert property (rx_frame_arrive_i && rx_desc_owned_i
        && rx_state_o == PROC_SUSP |-> ##2 rx_state_o == PROC_RUN) else $error("rx not resumed");
    cover property (tx_jabber_expired_i && tx_state_o == PROC_SUSP);
    cover property (rx_frame_arrive_i && rx_state_o == PROC_SUSP);
    cover property (wb_ack_o && !wb_we_i);
endmodule // mac_status_flags_low_checker

bind mac_status_flags_low mac_status_flags_low_checker i_chk (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .rx_desc_fetch_fail_i, .rx_desc_owned_i, .rx_frame_arrive_i, .tx_fifo_empty_i,
    .tx_frame_active_i, .tx_jabber_expired_i, .tx_desc_status_word_o, .tx_desc_status_we_o,
    .rx_state_o, .tx_state_o
);

// ===== verif/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model
    import mac_status_pkg::*;
(
    input wire logic clk_i,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [mac_status_pkg::ADR_W-1:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end
    // Ack is a register, so a rising edge sees the value it had just before that edge
    task automatic access(input logic we, input logic [ADR_W-1:0] a, input logic [3:0] s,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= a;
        wb_sel_o <= s;
        wb_dat_o <= d;
        do @(posedge clk_i); while (wb_ack_i !== 1'b1);
        q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
        // Released lines must not keep looking valid
        wb_adr_o <= ~a;
        wb_dat_o <= ~d;
    endtask
endmodule // host_bus_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
    import mac_status_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] ev = 8'h00;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_desc_status_we_o, irq_o;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, tx_desc_status_word_o, rd;
    proc_state_t rx_state_o, tx_state_o;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] em [6] = '{8'h01, 8'h10, 8'h80, 8'h60, 8'h02, 8'h20};
    logic [31:0] ef [6] = '{32'h200, 32'h40, 32'h8, 32'h20, 32'h80, 32'h0};
    mac_status_flags_low i_mac_status_flags_low (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .rx_watchdog_expired_i(ev[0]), .rx_desc_fetch_fail_i(ev[1]),
        .rx_desc_owned_i(ev[2]), .rx_frame_arrive_i(ev[3]), .rx_frame_done_i(ev[4]),
        .tx_fifo_empty_i(ev[5]), .tx_frame_active_i(ev[6]), .tx_jabber_expired_i(ev[7]),
        .tx_desc_status_word_o, .tx_desc_status_we_o, .rx_state_o, .tx_state_o, .irq_o
    );
    host_bus_model i_host (
        .clk_i, .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
        .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
        .wb_dat_o(wb_dat_i)
    );
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
        i_host.access(1'b1, a, 4'hF, d, rd);
    endtask
    task automatic rchk(input logic [ADR_W-1:0] a, input logic [31:0] e);
        i_host.access(1'b0, a, 4'hF, WORD_ZERO, rd);
        `CHK(rd, e)
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge clk_i);
        ev <= ev | m;
        @(posedge clk_i);
        ev <= ev & ~m;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(OFS_SECONDARY_STATUS, 32'h100);
        rchk(OFS_IRQ_MASK, WORD_ZERO);
        rchk(OFS_PROC_STATE, WORD_ZERO);
        wr(8'h40, 32'hFFFF_FFFF);
        rchk(8'h40, WORD_ZERO);
        rchk(OFS_PROC_CMD, WORD_ZERO);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            pulse(em[i]);
            rchk(OFS_SECONDARY_STATUS, ef[i] | 32'h100);
            wr(OFS_SECONDARY_STATUS, ~ef[i]);
            rchk(OFS_PRIMARY_STATUS, ef[i] | 32'h100);
            wr(OFS_PRIMARY_STATUS, ef[i]);
            rchk(OFS_SECONDARY_STATUS, 32'h100);
        end
        $display("test flags done");
        wr(OFS_PROC_CMD, 32'h1);
        wr(OFS_SECONDARY_STATUS, 32'h100);
        rchk(OFS_SECONDARY_STATUS, WORD_ZERO);
        pulse(8'h02);
        rchk(OFS_PROC_STATE, 32'h2);
        `CHK(rx_state_o, PROC_SUSP)
        pulse(8'h08);
        rchk(OFS_PROC_STATE, 32'h2);
        @(posedge clk_i);
        ev[2] <= 1'b1;
        pulse(8'h08);
        rchk(OFS_PROC_STATE, 32'h1);
        pulse(8'h02);
        // Ownership is already back with the device before the poll demand
        wr(OFS_PROC_CMD, 32'h4);
        rchk(OFS_PROC_STATE, 32'h1);
        wr(OFS_PROC_CMD, 32'h2);
        rchk(OFS_SECONDARY_STATUS, 32'h180);
        $display("test receive done");
        wr(OFS_IRQ_MASK, 32'hFFFF_FFFF);
        rchk(OFS_IRQ_MASK, 32'h3E8);
        wr(OFS_IRQ_MASK, 32'h40);
        wr(OFS_SECONDARY_STATUS, 32'h80);
        pulse(8'h10);
        repeat (2) @(negedge clk_i);
        `CHK(irq_o, 1'b1)
        wr(OFS_IRQ_MASK, WORD_ZERO);
        repeat (2) @(negedge clk_i);
        `CHK(irq_o, 1'b0)
        wr(OFS_IRQ_MASK, 32'h40);
        wr(OFS_SECONDARY_STATUS, 32'h40);
        repeat (2) @(negedge clk_i);
        `CHK(irq_o, 1'b0)
        $display("test interrupt done");
        wr(OFS_PROC_CMD, 32'h100);
        pulse(8'h60);
        @(negedge clk_i);
        `CHK(tx_desc_status_we_o, 1'b1)
        `CHK(tx_desc_status_word_o, 32'h0000_0002)
        rchk(OFS_PROC_STATE, 32'h200);
        `CHK(tx_state_o, PROC_SUSP)
        wr(OFS_PROC_STATE, 32'hFFFF_FFFF);
        rchk(OFS_PROC_STATE, 32'h200);
        pulse(8'h80);
        @(negedge clk_i);
        `CHK(tx_desc_status_word_o, 32'h0000_4000)
        rchk(OFS_PROC_STATE, WORD_ZERO);
        `CHK(tx_state_o, PROC_STOP)
        `CHK(tx_desc_status_we_o, 1'b0)
        rchk(OFS_SECONDARY_STATUS, 32'h128);
        $display("test transmit done");
        end_sim();
    end
endmodule // testbench
